/* File: core/otfr_core.sv */
// Purpose: over-temperature reaction controller with status and host notice
// Assumes: command port carries decoded bus transactions; samples are synchronous
// Notes: output stage enable and all status come straight from flip-flops
`timescale 1ns/100ps
module otfr_core import otfr_pkg::*; #(
  parameter int STEP_CYC = DELAY_STEP_CYC // cycles in one 10 ms step
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // command port
  input wire otfr_cmd_t cmd_i,
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  // telemetry and limits
  input wire otfr_sample_t sample_i,
  input wire logic [7:0] fault_limit_i,
  input wire logic [7:0] warn_limit_i,
  input wire logic [23:0] rise_time_cyc_i,
  // power stage
  input wire logic enable_i,
  input wire logic startup_done_i,
  output logic power_stage_en_o,
  // status and notice
  output otfr_status_t status_o,
  output logic alert_n_o
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_r, rst_sync_r; // two-stage release of the async reset
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  // every assertion below runs on the core clock and sleeps through reset
  default clocking dcb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_sync_r);
  logic [7:0] cfg_r, cfg_nxt; // reaction byte
  logic rd_valid_r, rd_valid_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  otfr_status_t stat_r, stat_nxt; // sticky status
  logic alert_n_r, alert_n_nxt;
  logic fault_act_r, fault_act_nxt; // fault condition held
  otfr_state_t state_r, state_nxt;
  logic [2:0] tries_r, tries_nxt; // restart attempts made
  logic out_en_r, out_en_nxt;
  logic tmr_start; // load the shared timer
  logic [23:0] tmr_len;
  logic [2:0] tmr_units;
  logic tmr_done;
  logic [1:0] sel;
  logic [2:0] pol, dly;
  logic cfg_hit, clr_hit, bad_wr;
  logic [7:0] rel_thr; // release threshold
  logic fault_evt, rel_evt;
  logic [2:0] hic_units;

  assign sel = cfg_r[SEL_MSB:SEL_LSB];
  assign pol = cfg_r[POL_MSB:POL_LSB];
  assign dly = cfg_r[DLY_MSB:DLY_LSB];
  assign hic_units = (dly == 3'h0) ? 3'h1 : dly;

  // ----------------------------------------------------------------
  // command decode and reaction byte
  // ----------------------------------------------------------------
  // a reaction byte write that carries anything but one data byte is unsupported data
  always_comb begin
    cfg_hit = cmd_i.valid && (cmd_i.code == CMD_REACTION_CFG);
    clr_hit = cmd_i.valid && cmd_i.write && (cmd_i.code == CMD_CLEAR_FAULTS);
    bad_wr = cfg_hit && cmd_i.write && (cmd_i.len != BYTE_LEN);
    cfg_nxt = cfg_r;
    rd_valid_nxt = 1'b0;
    rd_data_nxt = rd_data_r;
    if (cfg_hit && cmd_i.write && !bad_wr) begin
      cfg_nxt = cmd_i.data;
    end else if (cfg_hit && !cmd_i.write) begin
      rd_valid_nxt = 1'b1;
      rd_data_nxt = cfg_r;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      cfg_r <= CFG_RST;
      rd_valid_r <= 1'b0;
      rd_data_r <= 8'h00;
    end else begin
      cfg_r <= cfg_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  // ----------------------------------------------------------------
  // fault detection and release
  // ----------------------------------------------------------------
  // fault is edge-like: one event per excursion, held until release or a clear during cool-down
  always_comb begin
    if ((warn_limit_i > fault_limit_i) || (warn_limit_i == WARN_DISABLED_C)) begin
      // saturate so a low limit cannot wrap the threshold
      rel_thr = (fault_limit_i > DEFAULT_HYST_C) ?
        fault_limit_i - DEFAULT_HYST_C : 8'h00;
    end else begin
      rel_thr = warn_limit_i;
    end
    fault_evt = sample_i.valid && !fault_act_r &&
      (sample_i.temp >= fault_limit_i);
    rel_evt = sample_i.valid && fault_act_r && (sample_i.temp < rel_thr);
    fault_act_nxt = fault_act_r;
    if (fault_evt) begin
      fault_act_nxt = 1'b1;
    end else if (rel_evt) begin
      fault_act_nxt = 1'b0;
    end else if (clr_hit && state_r == ST_COOL) begin
      // dropping the held fault here strands the cool-down wait until the
      // next excursion or a disable, as the hardware is known to do
      fault_act_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sticky status and alert
  // ----------------------------------------------------------------
  // sets win over a clear arriving in the same cycle
  always_comb begin
    stat_nxt = stat_r;
    if (clr_hit) begin
      stat_nxt = '0;
    end
    if (fault_evt) begin
      stat_nxt.temp_summary = 1'b1;
      stat_nxt.thermal_fault_flag = 1'b1;
    end
    if (bad_wr) begin
      stat_nxt.cml_invalid_data = 1'b1;
    end
    alert_n_nxt = !(|stat_nxt);
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      stat_r <= '0;
      alert_n_r <= 1'b1;
      fault_act_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      alert_n_r <= alert_n_nxt;
      fault_act_r <= fault_act_nxt;
    end
  end

  // ----------------------------------------------------------------
  // reaction state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    tries_nxt = tries_r;
    tmr_start = 1'b0;
    tmr_len = rise_time_cyc_i;
    tmr_units = hic_units;
    case (state_r)
      ST_OFF: begin
        tries_nxt = 3'h0;
        if (enable_i && !fault_act_r) begin
          state_nxt = ST_START;
        end
      end
      ST_START, ST_RUN: begin
        if (state_r == ST_START && startup_done_i) begin
          state_nxt = ST_RUN;
          tries_nxt = 3'h0;
        end
        if (fault_evt) begin
          case (sel)
            SEL_IGNORE: begin
              state_nxt = state_r;
            end
            SEL_DELAYED: begin
              if (dly == 3'h0) begin
                state_nxt = (pol == POL_LATCH) ? ST_LATCH : ST_HICCUP;
                tmr_start = 1'b1;
              end else begin
                state_nxt = ST_DELAY;
                tmr_start = 1'b1;
                tmr_len = STEP_CYC[23:0];
                tmr_units = dly;
              end
            end
            SEL_IMMEDIATE: begin
              state_nxt = (pol == POL_LATCH) ? ST_LATCH : ST_HICCUP;
              tmr_start = 1'b1;
            end
            default: begin
              state_nxt = ST_COOL;
            end
          endcase
        end
      end
      ST_DELAY: begin
        if (tmr_done) begin
          if (fault_act_r) begin
            state_nxt = (pol == POL_LATCH) ? ST_LATCH : ST_HICCUP;
            tmr_start = 1'b1;
          end else begin
            state_nxt = ST_RUN;
          end
        end
      end
      ST_COOL: begin
        if (rel_evt) begin
          state_nxt = (pol == POL_LATCH) ? ST_LATCH : ST_HICCUP;
          tmr_start = 1'b1;
        end
      end
      ST_HICCUP: begin
        if (tmr_done) begin
          if (pol != POL_ENDLESS) begin
            tries_nxt = tries_r + 3'h1;
          end
          if (!fault_act_r) begin
            state_nxt = ST_START;
          end else if (pol != POL_ENDLESS && tries_nxt >= pol) begin
            state_nxt = ST_LATCH;
          end else begin
            tmr_start = 1'b1;
          end
        end
      end
      default: begin
        state_nxt = ST_LATCH;
      end
    endcase
    // a failed visible attempt that reaches the limit latches off
    if (state_nxt == ST_HICCUP && pol != POL_ENDLESS && tries_r >= pol &&
        state_r != ST_HICCUP) begin
      state_nxt = ST_LATCH;
    end
    if (!enable_i) begin
      state_nxt = ST_OFF; // commanded off leaves every state
    end
    out_en_nxt = (state_nxt == ST_START) || (state_nxt == ST_RUN) ||
      (state_nxt == ST_DELAY);
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= ST_OFF;
      tries_r <= 3'h0;
      out_en_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tries_r <= tries_nxt;
      out_en_r <= out_en_nxt;
    end
  end

  // one timer serves both the shutdown delay and the hiccup wait
  otfr_timer otfr_timer_i (
    .clk_i(core_clk_i),
    .rst_n_i(rst_sync_r),
    .start_i(tmr_start),
    .unit_len_i(tmr_len),
    .units_i(tmr_units),
    .done_o(tmr_done)
  );

  assign rd_valid_o = rd_valid_r;
  assign rd_data_o = rd_data_r;
  assign power_stage_en_o = out_en_r;
  assign status_o = stat_r;
  assign alert_n_o = alert_n_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_cfg_read; (cfg_hit && !cmd_i.write) |=>
    (rd_valid_o && rd_data_o == $past(cfg_r)); endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("read of reaction byte wrong");
  property p_summary; fault_evt |=> status_o.temp_summary; endproperty
  a_summary: assert property (p_summary) else $error("summary bit not set");
  property p_flag; fault_evt |=> status_o.thermal_fault_flag; endproperty
  a_flag: assert property (p_flag) else $error("fault flag not set");
  property p_alert; (fault_evt || bad_wr) |-> ##1 !alert_n_o; endproperty
  a_alert: assert property (p_alert) else $error("alert not raised");
  property p_ignore; (state_r == ST_RUN && sel == SEL_IGNORE && fault_evt && enable_i) |=>
    (state_r == ST_RUN && power_stage_en_o); endproperty
  a_ignore: assert property (p_ignore) else $error("ignore mode interrupted output");
  property p_immediate; (state_r == ST_RUN && sel == SEL_IMMEDIATE && fault_evt) |=>
    !power_stage_en_o; endproperty
  a_immediate: assert property (p_immediate) else $error("no immediate shutdown");
  property p_latch; (state_r == ST_LATCH && enable_i) |=>
    (state_r == ST_LATCH && !power_stage_en_o); endproperty
  a_latch: assert property (p_latch) else $error("latched off state left");
  property p_refuse; (state_r == ST_OFF && fault_act_r) |=> !power_stage_en_o; endproperty
  a_refuse: assert property (p_refuse) else $error("started with fault present");
  property p_invalid; bad_wr |=>
    (status_o.cml_invalid_data && cfg_r == $past(cfg_r)); endproperty
  a_invalid: assert property (p_invalid) else $error("invalid write not flagged");
  c_hiccup: cover property (state_r == ST_HICCUP ##1 state_r == ST_START);
  c_delay: cover property (state_r == ST_DELAY ##1 state_r == ST_HICCUP);
  c_cool: cover property (state_r == ST_COOL && rel_evt);
endmodule

/* File: core/otfr_pkg.sv */
// Purpose: shared constants and carriers for the over-temperature reaction block
// Assumes: one 250 MHz clock; temperatures are whole degrees C, unsigned 8 bit
// Notes: config reset value stands in for a non-volatile default
package otfr_pkg;
  // ----------------------------------------------------------------
  // command codes and register layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_REACTION_CFG = 8'h50; // reaction byte
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03; // clears sticky status
  localparam logic [7:0] CFG_RST = 8'h80; // immediate shutdown, latch off
  localparam int SEL_MSB = 7; // reaction_select 7:6
  localparam int SEL_LSB = 6;
  localparam int POL_MSB = 5; // restart_policy 5:3
  localparam int POL_LSB = 3;
  localparam int DLY_MSB = 2; // shutdown_hiccup_delay 2:0
  localparam int DLY_LSB = 0;
  localparam logic [1:0] BYTE_LEN = 2'h1; // legal data length of a write
  // ----------------------------------------------------------------
  // reaction and policy codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_IGNORE = 2'h0;
  localparam logic [1:0] SEL_DELAYED = 2'h1;
  localparam logic [1:0] SEL_IMMEDIATE = 2'h2;
  localparam logic [1:0] SEL_UNTIL_COOL = 2'h3;
  localparam logic [2:0] POL_LATCH = 3'h0;
  localparam logic [2:0] POL_ENDLESS = 3'h7;
  // ----------------------------------------------------------------
  // temperature and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] WARN_DISABLED_C = 8'hFF; // 255 C turns warning off
  localparam logic [7:0] DEFAULT_HYST_C = 8'h14; // 20 C fallback hysteresis
  localparam int CLK_PERIOD_NS = 4;
  localparam int DELAY_STEP_MS = 10; // shutdown delay step
  localparam int DELAY_STEP_CYC = DELAY_STEP_MS * 1000000 / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid; // one-cycle command strobe
    logic write; // 1 write, 0 read
    logic [7:0] code; // command code
    logic [1:0] len; // data bytes carried by a write
    logic [7:0] data; // write data
  } otfr_cmd_t;
  typedef struct packed {
    logic valid; // new sample strobe
    logic [7:0] temp; // die temperature, C
  } otfr_sample_t;
  typedef struct packed {
    logic temp_summary; // summary bit of the status byte
    logic thermal_fault_flag; // fault bit of temperature status
    logic cml_invalid_data; // invalid data bit of comms status
  } otfr_status_t;
  typedef enum logic [6:0] {
    ST_OFF = 7'h01,
    ST_START = 7'h02,
    ST_RUN = 7'h04,
    ST_DELAY = 7'h08,
    ST_COOL = 7'h10,
    ST_HICCUP = 7'h20,
    ST_LATCH = 7'h40
  } otfr_state_t;
endpackage

/* File: core/otfr_timer.sv */
// Purpose: down counter of whole units, each unit a programmable number of cycles
// Assumes: start reloads even while running
// Notes: zero units run as one unit; zero unit length makes each unit one cycle
`timescale 1ns/100ps
module otfr_timer import otfr_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic start_i,
  input wire logic [23:0] unit_len_i,
  input wire logic [2:0] units_i,
  // result
  output logic done_o
);
  logic [23:0] cyc_r, cyc_nxt; // cycles left in the unit
  logic [2:0] units_r, units_nxt; // units left
  logic run_r, run_nxt;
  logic done_r, done_nxt;
  logic [23:0] last_cyc; // reload value, guarded against zero

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    last_cyc = (unit_len_i == 24'h0) ? 24'h0 : unit_len_i - 24'h1;
    cyc_nxt = cyc_r;
    units_nxt = units_r;
    run_nxt = run_r;
    done_nxt = 1'b0;
    if (start_i) begin
      cyc_nxt = last_cyc;
      units_nxt = units_i;
      run_nxt = 1'b1;
    end else if (run_r) begin
      if (cyc_r != 24'h0) begin
        cyc_nxt = cyc_r - 24'h1;
      end else if (units_r <= 3'h1) begin
        run_nxt = 1'b0; // last unit spent
        done_nxt = 1'b1;
      end else begin
        units_nxt = units_r - 3'h1;
        cyc_nxt = last_cyc;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc_r <= 24'h0;
      units_r <= 3'h0;
      run_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cyc_r <= cyc_nxt;
      units_r <= units_nxt;
      run_r <= run_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_o = done_r;
endmodule

/* File: verification/otfr_host_model.sv */
// Purpose: host side of the command port, issuing byte reads and byte writes
// Assumes: requests are launched on the falling clock edge, one cycle each
// Notes: idle command fields show the inverse of the last request, never a held copy
`timescale 1ns/100ps
module otfr_host_model import otfr_pkg::*; (
  // clock
  input wire logic clk_i,
  // command port
  output otfr_cmd_t cmd_o,
  input wire logic rd_valid_i,
  input wire logic [7:0] rd_data_i
);
  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // quiet port from time zero
  initial begin
    cmd_o = '0;
  end
  // one strobe cycle; the fields are scrambled once taken, so no stale value can pass
  task automatic issue(input logic wr, input logic [7:0] code, input logic [1:0] len,
                       input logic [7:0] data);
    @(negedge clk_i);
    cmd_o = '{valid: 1'b1, write: wr, code: code, len: len, data: data};
    @(negedge clk_i);
    cmd_o = '{valid: 1'b0, write: ~wr, code: ~code, len: ~len, data: ~data};
  endtask
  // single byte write of the reaction byte or a clear request
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    issue(1'b1, code, BYTE_LEN, data);
  endtask
  // single byte read: the answer stands only in the cycle after the taking edge
  task automatic rd(input logic [7:0] code, output logic [7:0] data, output logic ok);
    @(negedge clk_i);
    cmd_o = '{valid: 1'b1, write: 1'b0, code: code, len: BYTE_LEN, data: 8'h00};
    @(negedge clk_i);
    // take the answer while it stands, then drop the strobe
    ok = rd_valid_i;
    data = rd_data_i;
    cmd_o = '{valid: 1'b0, write: 1'b1, code: ~code, len: ~BYTE_LEN, data: 8'hFF};
  endtask
endmodule

/* File: verification/tb_otfr_core.sv */
// Purpose: self-checking bench for the over-temperature reaction controller
// Assumes: fault limit 100 C, warning 80 C, short delay step and rise time
// Notes: timing windows are loose by a few cycles; exact edges are left to assertions
`timescale 1ns/100ps
module tb_otfr_core import otfr_pkg::*; ;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  localparam int STEP = 20; // cycles in one shortened delay step
  localparam int RT = 8; // rise time in cycles, the hiccup unit
  logic core_clk_i, rst_n_i, rd_valid, enable, startup_done, power_en, alert_n, ok;
  logic [7:0] rd_data, fault_lim, warn_lim, v;
  logic [23:0] rise_cyc;
  otfr_cmd_t cmd;
  otfr_sample_t sample;
  otfr_status_t status;
  int err_total, check_count, n;
  otfr_core #(.STEP_CYC(STEP)) otfr_core_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .cmd_i(cmd), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .sample_i(sample),
    .fault_limit_i(fault_lim), .warn_limit_i(warn_lim), .rise_time_cyc_i(rise_cyc),
    .enable_i(enable), .startup_done_i(startup_done), .power_stage_en_o(power_en),
    .status_o(status), .alert_n_o(alert_n));
  otfr_host_model otfr_host_model_i (.clk_i(core_clk_i), .cmd_o(cmd),
    .rd_valid_i(rd_valid), .rd_data_i(rd_data));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk_i);
  endtask
  // one telemetry sample; the temperature is scrambled once taken
  task automatic samp(input logic [7:0] t);
    @(negedge core_clk_i);
    sample = '{valid: 1'b1, temp: t};
    @(negedge core_clk_i);
    sample = '{valid: 1'b0, temp: ~t};
  endtask
  // counts cycles until the output stage reaches the wanted level, capped
  task automatic wait_pwr(input logic lvl, input int cap, output int k);
    k = 0;
    while (power_en !== lvl && k < cap) begin
      @(negedge core_clk_i);
      k++;
    end
  endtask
  // cool down, cycle the enable, finish start-up and clear status
  task automatic recover(input string name);
    samp(8'h19);
    enable = 1'b0;
    cyc(2);
    enable = 1'b1;
    wait_pwr(1'b1, 20, n);
    startup_done = 1'b1;
    cyc(1);
    startup_done = 1'b0;
    otfr_host_model_i.wr(CMD_CLEAR_FAULTS, 8'h00);
    cyc(2);
    chk({4'h0, status, alert_n}, 8'h01, "status after clear");
    $display("test %s done", name);
  endtask
  // hot then cool sample; the off time must match the hiccup of the byte
  task automatic hiccup(input logic [7:0] cfg, input int lo, input string name);
    otfr_host_model_i.wr(CMD_REACTION_CFG, cfg);
    samp(8'h78);
    wait_pwr(1'b0, 10, n);
    samp(8'h19);
    wait_pwr(1'b1, lo + 20, n);
    chk(8'(n >= lo - 3 && n <= lo + 4), 8'h01, "off time");
    recover(name);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // a hang counts as a mismatch and ends the run the usual way
  initial begin
    #80000;
    err_total++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    sample = '0;
    // limit kept above the start-up heat
    fault_lim = 8'h64;
    warn_lim = 8'h50;
    rise_cyc = 24'(RT);
    enable = 1'b1;
    startup_done = 1'b0;
    err_total = 0;
    check_count = 0;
    cyc(5);
    rst_n_i = 1'b1;
    cyc(5);
    samp(8'h19);
    // reset byte, then a write and read back
    otfr_host_model_i.rd(CMD_REACTION_CFG, v, ok);
    chk({ok, 7'h0} | 8'(v == CFG_RST), 8'h81, "reset byte");
    otfr_host_model_i.wr(CMD_REACTION_CFG, 8'h00);
    otfr_host_model_i.rd(CMD_REACTION_CFG, v, ok);
    chk(v, 8'h00, "byte read back");
    // a two byte write is refused and flagged
    otfr_host_model_i.issue(1'b1, CMD_REACTION_CFG, 2'h2, 8'hFF);
    cyc(2);
    chk({6'h0, status.cml_invalid_data, alert_n}, 8'h02, "invalid data");
    otfr_host_model_i.rd(CMD_REACTION_CFG, v, ok);
    chk(v, 8'h00, "byte kept");
    recover("access");
    // ignore mode: a sample exactly at the limit flags, output keeps running
    samp(8'h64);
    cyc(2);
    chk({5'h0, status.temp_summary, status.thermal_fault_flag, !alert_n}, 8'h07,
        "fault flags");
    cyc(40);
    chk({7'h0, power_en}, 8'h01, "ignore keeps running");
    recover("ignore");
    // hiccup lengths for delay 0, delay 2, delayed mode with no delay, and cool-down mode
    hiccup(8'h88, RT, "hiccup one");
    hiccup(8'h8A, 2 * RT, "hiccup two");
    hiccup(8'h48, RT, "delay zero");
    hiccup(8'hF8, RT, "until cool");
    // one attempt while still hot is invisible, then the device latches
    otfr_host_model_i.wr(CMD_REACTION_CFG, 8'h88);
    samp(8'h78);
    cyc(3 * RT);
    chk({7'h0, power_en}, 8'h00, "hot attempt hidden");
    samp(8'h19);
    cyc(3 * RT);
    chk({7'h0, power_en}, 8'h00, "latched after one");
    recover("retry limit");
    // clear during cool-down drops the held fault: off until a fresh excursion ends
    otfr_host_model_i.wr(CMD_REACTION_CFG, 8'hC8);
    samp(8'h78);
    otfr_host_model_i.wr(CMD_CLEAR_FAULTS, 8'h00);
    samp(8'h19);
    cyc(3 * RT);
    chk({7'h0, power_en}, 8'h00, "stuck after clear");
    samp(8'h78);
    samp(8'h19);
    wait_pwr(1'b1, 3 * RT, n);
    chk({7'h0, power_en}, 8'h01, "restart after excursion");
    recover("clear in cool");
    // delayed shutdown of one step, then latch off
    otfr_host_model_i.wr(CMD_REACTION_CFG, 8'h41);
    samp(8'h78);
    wait_pwr(1'b0, STEP + 20, n);
    chk(8'(n >= STEP - 3 && n <= STEP + 4), 8'h01, "delay time");
    samp(8'h19);
    cyc(3 * RT);
    chk({7'h0, power_en}, 8'h00, "latch off");
    recover("delayed");
    // warning disabled or above the limit: release only below limit minus 20
    for (int i = 0; i < 2; i++) begin
      warn_lim = (i == 0) ? WARN_DISABLED_C : 8'h78;
      otfr_host_model_i.wr(CMD_REACTION_CFG, 8'hB8);
      samp(8'h6E);
      samp(8'h50);
      cyc(3 * RT);
      chk({7'h0, power_en}, 8'h00, "held at 80");
      samp(8'h4F);
      wait_pwr(1'b1, 3 * RT, n);
      chk({7'h0, power_en}, 8'h01, "released at 79");
      warn_lim = 8'h50;
      recover("hysteresis");
    end
    // no start-up while a fault is held at enable, even in ignore mode
    otfr_host_model_i.wr(CMD_REACTION_CFG, 8'h00);
    enable = 1'b0;
    cyc(2);
    samp(8'h78);
    enable = 1'b1;
    cyc(30);
    chk({7'h0, power_en}, 8'h00, "start refused");
    samp(8'h19);
    wait_pwr(1'b1, 20, n);
    chk({7'h0, power_en}, 8'h01, "start after cool");
    recover("enable hot");
    end_of_test();
  end
endmodule
